// ### host_model.sv
// host computer model: terminal end of the serial link
`default_nettype none
module host_model (
    input wire logic clk,
    input wire logic txd,
    output logic rxd,
    output logic dtr
);
    timeunit 1ns;
    timeprecision 1ns;
    int bit_cyc = 512;
    int bad = 0;
    logic [1:0] par = 2'h0;
    logic [7:0] q[$];
    // host drives its data line, so idle is a real mark level
    initial begin
        rxd = 1'b1;
        dtr = 1'b1; // host ready to take characters
    end
    // one frame out, lsb first, stop length in sixteenths of a bit
    task automatic send(input logic [7:0] d, input logic flip, input int stop16);
        logic [9:0] f;
        f = {(^d) ^ (par == 2'h2) ^ flip, d, 1'b0};
        for (int i = 0; i < ((par != 2'h0) ? 10 : 9); i++) begin
            @(negedge clk);
            rxd = f[i];
            repeat (bit_cyc - 1) @(negedge clk);
        end
        rxd = 1'b1;
        repeat (bit_cyc * stop16 / 16) @(negedge clk);
    endtask : send
    // decodes each frame from the port at mid-bit; bad counts parity and stop-bit faults
    always begin : rx_frames
        logic [7:0] d;
        @(negedge txd);
        repeat (bit_cyc / 2) @(posedge clk);
        if (txd == 1'b0) begin
            for (int i = 0; i < 8; i++) begin
                repeat (bit_cyc) @(posedge clk);
                d[i] = txd;
            end
            if (par != 2'h0) begin
                repeat (bit_cyc) @(posedge clk);
                if (txd !== ((^d) ^ (par == 2'h2)))
                    bad++;
            end
            repeat (bit_cyc) @(posedge clk);
            if (txd !== 1'b1)
                bad++;
            q.push_back(d);
        end
    end
endmodule : host_model
`default_nettype wire

// ### instrument_serial_host_port.sv
// serial remote-control port, communications-equipment end
`default_nettype none
`include "serial_port_cfg.svh"
module instrument_serial_host_port
    import serial_port_pkg::*;
#(
    parameter logic [23:0] ONE_SEC = `ONE_SEC_CYCLES
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic rxd,
    output logic txd,
    input wire logic dtr,
    output logic dsr,
    input wire logic cfg_write,
    input wire logic [3:0] baud_sel,
    input wire logic [1:0] stop_sel,
    input wire logic [1:0] parity_sel,
    input wire logic [1:0] flow_sel,
    input wire logic echo_en,
    input wire logic [5:0] delay_sec,
    input wire logic [1:0] reply_terminator_select,
    input wire logic verbose_en,
    input wire logic debug_en,
    input wire logic settings_init,
    input wire logic [7:0] rx_space,
    output logic [7:0] rx_data,
    output logic rx_valid,
    output logic rx_parity_err,
    output logic rx_frame_err,
    output logic [7:0] command_trace_display,
    output logic trace_valid,
    input wire logic cmd_received,
    input wire logic cmd_done,
    input wire logic cmd_ok,
    input wire logic [7:0] reply_data,
    input wire logic reply_valid,
    input wire logic reply_last,
    output logic reply_ready
);
    // configuration, written only by cfg_write, never by settings_init
    logic [3:0] baud_reg;
    stop_t stop_reg;
    parity_t par_reg;
    flow_t flow_reg;
    logic echo_reg, verbose_reg, debug_reg;
    logic [5:0] delay_reg;
    term_t term_reg;
    always_ff @(posedge clk) begin
        if (!nrst) begin
            baud_reg <= `BAUD_RESET;
            stop_reg <= STOP_1;
            par_reg <= PAR_NONE;
            flow_reg <= FLOW_NONE;
            echo_reg <= 1'b0;
            verbose_reg <= 1'b0;
            debug_reg <= 1'b0;
            delay_reg <= 6'h00;
            term_reg <= TERM_LF;
        end else if (cfg_write) begin
            baud_reg <= baud_sel;
            stop_reg <= stop_t'(stop_sel);
            par_reg <= parity_t'(parity_sel);
            flow_reg <= flow_t'(flow_sel);
            echo_reg <= echo_en;
            verbose_reg <= verbose_en;
            debug_reg <= debug_en; // off after reset, the normal mode
            delay_reg <= (delay_sec > `DELAY_MAX_SEC) ? `DELAY_MAX_SEC : delay_sec;
            term_reg <= term_t'(reply_terminator_select);
        end
    end

    function automatic logic [12:0] baud_div(input logic [3:0] sel);
        unique case (sel)
            4'h0: baud_div = `DIV_110;
            4'h1: baud_div = `DIV_150;
            4'h2: baud_div = `DIV_300;
            4'h3: baud_div = `DIV_600;
            4'h4: baud_div = `DIV_1200;
            4'h5: baud_div = `DIV_2400;
            4'h6: baud_div = `DIV_4800;
            4'h7: baud_div = `DIV_9600;
            default: baud_div = `DIV_19200;
        endcase
    endfunction : baud_div

    function automatic logic [5:0] stop_ticks(input stop_t s);
        unique case (s)
            STOP_15: stop_ticks = `STOP_TICKS_15;
            STOP_2: stop_ticks = `STOP_TICKS_2;
            default: stop_ticks = `STOP_TICKS_1;
        endcase
    endfunction : stop_ticks

    // 16x oversample enable shared by both directions
    logic [12:0] div_reg;
    logic tick_reg;
    always_ff @(posedge clk) begin
        if (!nrst || cfg_write) begin
            div_reg <= 13'h0000;
            tick_reg <= 1'b0;
        end else if (div_reg >= baud_div(baud_reg) - 13'h0001) begin
            div_reg <= 13'h0000;
            tick_reg <= 1'b1;
        end else begin
            div_reg <= div_reg + 13'h0001;
            tick_reg <= 1'b0;
        end
    end

    // receiver: start bit found low, each bit sampled mid-cell
    frame_state_t rx_st;
    logic [3:0] rx_sub;
    logic [2:0] rx_bit;
    logic [7:0] rx_sh;
    logic rx_got;
    logic rx_par_bad;
    // parity result is held until the stop sample so both flags change with rx_valid
    always_ff @(posedge clk) begin
        if (!nrst) begin
            rx_st <= FR_IDLE;
            rx_par_bad <= 1'b0;
            rx_sub <= 4'h0;
            rx_bit <= 3'h0;
            rx_sh <= 8'h00;
            rx_data <= 8'h00;
            rx_valid <= 1'b0;
            rx_parity_err <= 1'b0;
            rx_frame_err <= 1'b0;
        end else begin
            rx_valid <= 1'b0;
            if (tick_reg) begin
                rx_sub <= rx_sub + 4'h1;
                unique case (rx_st)
                    FR_IDLE: begin
                        rx_sub <= 4'h0;
                        if (!rxd) rx_st <= FR_START;
                    end
                    FR_START: if (rx_sub == `MID_TICK) begin
                        rx_sub <= 4'h0;
                        rx_bit <= 3'h0;
                        rx_st <= rxd ? FR_IDLE : FR_DATA; // glitch rejected
                    end
                    FR_DATA: if (rx_sub == 4'hf) begin
                        rx_sh <= {rxd, rx_sh[7:1]}; // lsb first
                        rx_bit <= rx_bit + 3'h1;
                        if (rx_bit == 3'h7) rx_st <= (par_reg == PAR_NONE) ? FR_STOP : FR_PAR;
                    end
                    FR_PAR: if (rx_sub == 4'hf) begin
                        rx_par_bad <= (^rx_sh ^ rxd) != (par_reg == PAR_ODD);
                        rx_st <= FR_STOP;
                    end
                    FR_STOP: if (rx_sub == 4'hf) begin
                        // only the first stop bit is checked; longer stops look like idle
                        rx_frame_err <= !rxd;
                        rx_parity_err <= (par_reg != PAR_NONE) && rx_par_bad;
                        rx_data <= rx_sh;
                        rx_valid <= 1'b1;
                        rx_st <= FR_IDLE;
                    end
                endcase
            end
        end
    end
    assign rx_got = rx_valid;

    // debug trace of each received character
    always_ff @(posedge clk) begin
        if (!nrst) begin
            command_trace_display <= 8'h00;
            trace_valid <= 1'b0;
        end else begin
            trace_valid <= rx_got && debug_reg;
            if (rx_got && debug_reg) command_trace_display <= rx_data;
        end
    end

    // flow control: stop early so in-flight characters still fit
    logic stop_req, send_xoff, send_xon, peer_halt;
    always_ff @(posedge clk) begin
        if (!nrst) begin
            stop_req <= 1'b0;
            dsr <= 1'b1;
        end else begin
            if (rx_space <= `STOP_MARGIN) stop_req <= 1'b1;
            else if (rx_space >= `RESUME_MARGIN) stop_req <= 1'b0;
            dsr <= !(flow_reg == FLOW_HARD && stop_req);
        end
    end
    // in-band halt from the host holds until its resume character
    always_ff @(posedge clk) begin
        if (!nrst || flow_reg != FLOW_SOFT) peer_halt <= 1'b0;
        else if (rx_got && rx_data == `CHAR_XOFF) peer_halt <= 1'b1;
        else if (rx_got && rx_data == `CHAR_XON) peer_halt <= 1'b0;
    end

    // response delay timer, one-second enable from a divider
    logic [23:0] sec_cnt;
    logic [5:0] delay_left;
    always_ff @(posedge clk) begin
        if (!nrst || settings_init || cmd_received) begin
            sec_cnt <= 24'h000000;
            delay_left <= (!nrst || settings_init) ? 6'h00 : delay_reg;
        end else if (delay_left != 6'h00) begin
            if (sec_cnt == ONE_SEC - 24'h000001) begin
                sec_cnt <= 24'h000000;
                delay_left <= delay_left - 6'h01;
            end else begin
                sec_cnt <= sec_cnt + 24'h000001;
            end
        end
    end

    // pending transmit sources; each flag set wins over its own clear
    logic tx_busy, tx_load;
    logic [7:0] tx_byte;
    logic echo_pend, stat_pend, stat_ok, reply_pend, reply_end;
    logic [7:0] echo_byte, reply_byte;
    logic [1:0] term_left;
    logic xoff_sent;
    logic sel_flow, sel_echo, sel_stat, sel_term, sel_reply, may_send;
    assign may_send = !tx_busy && !tx_load && !peer_halt &&
        !(flow_reg == FLOW_HARD && !dtr);
    assign send_xoff = flow_reg == FLOW_SOFT && stop_req && !xoff_sent;
    assign send_xon = flow_reg == FLOW_SOFT && !stop_req && xoff_sent;
    // flow characters go out even while halted, replies wait for the delay
    assign sel_flow = !tx_busy && !tx_load && (send_xoff || send_xon);
    assign sel_echo = may_send && !sel_flow && echo_pend;
    assign sel_term = may_send && !sel_flow && !echo_pend && term_left != 2'h0;
    assign sel_stat = may_send && !sel_flow && !echo_pend && term_left == 2'h0 && stat_pend;
    assign sel_reply = may_send && !sel_flow && !echo_pend && term_left == 2'h0 &&
        !stat_pend && reply_pend && delay_left == 6'h00;

    always_ff @(posedge clk) begin
        if (!nrst || flow_reg != FLOW_SOFT) xoff_sent <= 1'b0;
        else if (sel_flow) xoff_sent <= send_xoff;
    end
    always_ff @(posedge clk) begin
        if (!nrst || !echo_reg) echo_pend <= 1'b0;
        else if (rx_got) echo_pend <= 1'b1;
        else if (sel_echo) echo_pend <= 1'b0;
        if (rx_got) echo_byte <= rx_data;
    end
    always_ff @(posedge clk) begin
        if (!nrst || settings_init) begin
            stat_pend <= 1'b0;
            stat_ok <= 1'b0;
        end else if (cmd_done && verbose_reg) begin
            stat_pend <= 1'b1;
            stat_ok <= cmd_ok;
        end else if (sel_stat) begin
            stat_pend <= 1'b0;
        end
    end
    // one-byte reply slot; ready drops as soon as a byte is taken
    always_ff @(posedge clk) begin
        if (!nrst || settings_init) begin
            reply_pend <= 1'b0;
            reply_end <= 1'b0;
            reply_byte <= 8'h00;
            reply_ready <= 1'b0;
        end else begin
            reply_ready <= !reply_pend && !(reply_valid && reply_ready) && term_left == 2'h0;
            if (reply_valid && reply_ready) begin
                reply_pend <= 1'b1;
                reply_byte <= reply_data;
                reply_end <= reply_last;
            end else if (sel_reply) begin
                reply_pend <= 1'b0;
            end
        end
    end
    // terminator after a reply's last byte or a status character
    always_ff @(posedge clk) begin
        if (!nrst || settings_init) term_left <= 2'h0;
        else if ((sel_reply && reply_end) || sel_stat)
            term_left <= (term_reg == TERM_CRLF || term_reg == TERM_LFCR) ? 2'h2 : 2'h1;
        else if (sel_term) term_left <= term_left - 2'h1;
    end

    function automatic logic [7:0] term_char(input term_t t, input logic [1:0] left);
        unique case (t)
            TERM_LF: term_char = `CHAR_LF;
            TERM_CR: term_char = `CHAR_CR;
            TERM_CRLF: term_char = (left == 2'h2) ? `CHAR_CR : `CHAR_LF;
            TERM_LFCR: term_char = (left == 2'h2) ? `CHAR_LF : `CHAR_CR;
        endcase
    endfunction : term_char

    always_ff @(posedge clk) begin
        if (!nrst) begin
            tx_load <= 1'b0;
            tx_byte <= 8'h00;
        end else begin
            tx_load <= sel_flow | sel_echo | sel_term | sel_stat | sel_reply;
            if (sel_flow) tx_byte <= send_xoff ? `CHAR_XOFF : `CHAR_XON;
            else if (sel_echo) tx_byte <= echo_byte;
            else if (sel_term) tx_byte <= term_char(term_reg, term_left);
            else if (sel_stat) tx_byte <= stat_ok ? `CHAR_CMD_OK : `CHAR_CMD_FAIL;
            else if (sel_reply) tx_byte <= reply_byte;
        end
    end

    // transmitter: start, 8 data lsb first, parity, stop of selected length
    frame_state_t tx_st;
    logic [5:0] tx_sub;
    logic [2:0] tx_bit;
    logic [7:0] tx_sh;
    logic tx_par;
    assign tx_busy = tx_st != FR_IDLE;
    always_ff @(posedge clk) begin
        if (!nrst) begin
            tx_st <= FR_IDLE;
            tx_sub <= 6'h00;
            tx_bit <= 3'h0;
            tx_sh <= 8'h00;
            tx_par <= 1'b0;
            txd <= 1'b1;
        end else if (tx_st == FR_IDLE) begin
            txd <= 1'b1;
            if (tx_load) begin
                tx_sh <= tx_byte;
                tx_par <= ^tx_byte ^ (par_reg == PAR_ODD);
                tx_sub <= 6'h00;
                tx_st <= FR_START;
            end
        end else if (tick_reg) begin
            tx_sub <= tx_sub + 6'h01;
            unique case (tx_st)
                FR_START: begin
                    txd <= 1'b0;
                    if (tx_sub == 6'h0f) begin
                        tx_sub <= 6'h00;
                        tx_bit <= 3'h0;
                        tx_st <= FR_DATA;
                    end
                end
                FR_DATA: begin
                    txd <= tx_sh[tx_bit];
                    if (tx_sub == 6'h0f) begin
                        tx_sub <= 6'h00;
                        tx_bit <= tx_bit + 3'h1;
                        if (tx_bit == 3'h7) tx_st <= (par_reg == PAR_NONE) ? FR_STOP : FR_PAR;
                    end
                end
                FR_PAR: begin
                    txd <= tx_par;
                    if (tx_sub == 6'h0f) begin
                        tx_sub <= 6'h00;
                        tx_st <= FR_STOP;
                    end
                end
                default: begin
                    txd <= 1'b1;
                    if (tx_sub == stop_ticks(stop_reg) - 6'h01) tx_st <= FR_IDLE;
                end
            endcase
        end
    end
endmodule : instrument_serial_host_port
`default_nettype wire

// ### instrument_serial_host_port_monitor.sv
// assertion checker for the serial host port
`default_nettype none
module instrument_serial_host_port_monitor (
    input wire logic clk,
    input wire logic nrst,
    input wire logic txd,
    input wire logic dsr,
    input wire logic [7:0] rx_space,
    input wire logic [7:0] rx_data,
    input wire logic rx_valid,
    input wire logic rx_parity_err,
    input wire logic rx_frame_err,
    input wire logic [7:0] command_trace_display,
    input wire logic trace_valid,
    input wire logic reply_valid,
    input wire logic reply_last,
    input wire logic reply_ready
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    // a last reply byte handed over, then reply_ready held low for the next eight cycles
    sequence taken_s;
        reply_valid && reply_ready && reply_last;
    endsequence
    sequence busy_s;
        !reply_ready [*8];
    endsequence
    AST_RESET_IDLE: assert property (disable iff (1'b0)
        !nrst |=> txd && dsr && !rx_valid && !trace_valid)
        else $error("outputs not idle after reset");
    AST_TRACE_COPY: assert property (trace_valid |->
        $past(rx_valid) && command_trace_display == $past(rx_data))
        else $error("trace byte not the received byte");
    AST_RX_PULSE: assert property (rx_valid |=> !rx_valid)
        else $error("receive strobe longer than one cycle");
    AST_DSR_CAUSE: assert property ($fell(dsr) |->
        $past(rx_space) <= 8'h02 || $past(rx_space, 2) <= 8'h02 || $past(rx_space, 3) <= 8'h02)
        else $error("ready line dropped with space free");
    AST_START_BIT: assert property ($fell(txd) |=> !txd [*8])
        else $error("start bit too short");
    AST_REPLY_BUSY: assert property (taken_s |=> busy_s)
        else $error("reply ready came back too soon");
    AST_PAR_FLAG: assert property ($changed(rx_parity_err) && $past(nrst) |-> rx_valid)
        else $error("parity flag moved without a character");
    AST_FRAME_FLAG: assert property ($changed(rx_frame_err) && $past(nrst) |-> rx_valid)
        else $error("framing flag moved without a character");
endmodule : instrument_serial_host_port_monitor
bind instrument_serial_host_port instrument_serial_host_port_monitor u_mon (
    .clk(clk), .nrst(nrst), .txd(txd), .dsr(dsr), .rx_space(rx_space), .rx_data(rx_data),
    .rx_valid(rx_valid), .rx_parity_err(rx_parity_err), .rx_frame_err(rx_frame_err),
    .command_trace_display(command_trace_display), .trace_valid(trace_valid),
    .reply_valid(reply_valid), .reply_last(reply_last), .reply_ready(reply_ready));
`default_nettype wire

// ### serial_port_cfg.svh
// constants for the instrument serial host port
`ifndef SERIAL_PORT_CFG_SVH
`define SERIAL_PORT_CFG_SVH
`define CLK_HZ 10000000
`define OVERSAMPLE 16
// baud divisors in clk cycles per 1/16 bit: clk_hz / (16 * rate)
`define DIV_110 13'd5682
`define DIV_150 13'd4166
`define DIV_300 13'd2083
`define DIV_600 13'd1041
`define DIV_1200 13'd520
`define DIV_2400 13'd260
`define DIV_4800 13'd130
`define DIV_9600 13'd65
`define DIV_19200 13'd32
// stop length in 1/16 bit ticks
`define STOP_TICKS_1 6'd16
`define STOP_TICKS_15 6'd24
`define STOP_TICKS_2 6'd32
`define MID_TICK 4'h7
`define CHAR_XON 8'h11
`define CHAR_XOFF 8'h13
`define CHAR_CR 8'h0d
`define CHAR_LF 8'h0a
`define CHAR_CMD_OK 8'h30
`define CHAR_CMD_FAIL 8'h31
`define DELAY_MAX_SEC 6'd60
`define ONE_SEC_CYCLES 24'd10000000
`define STOP_MARGIN 8'h02
`define RESUME_MARGIN 8'h08
`define BAUD_RESET 4'h7
`endif

// ### serial_port_pkg.sv
// types for the instrument serial host port
`default_nettype none
package serial_port_pkg;
    typedef enum logic [1:0] {PAR_NONE = 2'h0, PAR_EVEN = 2'h1, PAR_ODD = 2'h2} parity_t;
    typedef enum logic [1:0] {STOP_1 = 2'h0, STOP_15 = 2'h1, STOP_2 = 2'h2} stop_t;
    typedef enum logic [1:0] {FLOW_NONE = 2'h0, FLOW_HARD = 2'h1, FLOW_SOFT = 2'h2} flow_t;
    typedef enum logic [1:0] {TERM_LF = 2'h0, TERM_CR = 2'h1, TERM_CRLF = 2'h2,
        TERM_LFCR = 2'h3} term_t;
    typedef enum logic [4:0] {
        FR_IDLE = 5'b00001,
        FR_START = 5'b00010,
        FR_DATA = 5'b00100,
        FR_PAR = 5'b01000,
        FR_STOP = 5'b10000
    } frame_state_t;
endpackage : serial_port_pkg
`default_nettype wire

// ### tb_top.sv
// self-checking bench for the serial host port
`default_nettype none
`include "serial_port_cfg.svh"
module tb_top;
    import serial_port_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0, nrst = 1'b0, cfg_write = 1'b0, echo_en = 1'b0, verbose_en = 1'b0;
    logic debug_en = 1'b0, settings_init = 1'b0, cmd_received = 1'b0, cmd_done = 1'b0;
    logic cmd_ok = 1'b0, reply_valid = 1'b0, reply_last = 1'b0;
    logic [3:0] baud_sel = 4'h8;
    logic [1:0] stop_sel = 2'h0, parity_sel = 2'h0, flow_sel = 2'h0, term_sel = 2'h0;
    logic [5:0] delay_sec = 6'h00;
    logic [7:0] rx_space = 8'hff, reply_data = 8'h00;
    logic txd, rxd, dtr, dsr, rx_valid, rx_parity_err, rx_frame_err, trace_valid, reply_ready;
    logic [7:0] rx_data, trace_data;
    logic [7:0] exp_q[$];
    int n_fail = 0, samples_checked = 0;
    always #50 clk = ~clk;
    // one second shortened to 100 cycles so the delay fits the run
    instrument_serial_host_port #(.ONE_SEC(24'd100)) u_instrument_serial_host_port (
        .clk(clk), .nrst(nrst), .rxd(rxd), .txd(txd), .dtr(dtr), .dsr(dsr),
        .cfg_write(cfg_write), .baud_sel(baud_sel), .stop_sel(stop_sel),
        .parity_sel(parity_sel), .flow_sel(flow_sel), .echo_en(echo_en),
        .delay_sec(delay_sec), .reply_terminator_select(term_sel), .verbose_en(verbose_en),
        .debug_en(debug_en), .settings_init(settings_init), .rx_space(rx_space),
        .rx_data(rx_data), .rx_valid(rx_valid), .rx_parity_err(rx_parity_err),
        .rx_frame_err(rx_frame_err), .command_trace_display(trace_data),
        .trace_valid(trace_valid), .cmd_received(cmd_received), .cmd_done(cmd_done),
        .cmd_ok(cmd_ok), .reply_data(reply_data), .reply_valid(reply_valid),
        .reply_last(reply_last), .reply_ready(reply_ready));
    host_model u_host (.clk(clk), .txd(txd), .rxd(rxd), .dtr(dtr));
    task automatic check(input string name, input logic [8:0] seen, input logic [8:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic complete_run();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : complete_run
    // rate drawn from the settings that all mean the fastest rate, to keep the run short
    task automatic cfg(input logic [1:0] st, pa, fl, tm, input logic ec, vb, db,
        input logic [5:0] dl);
        @(negedge clk);
        {stop_sel, parity_sel, flow_sel, term_sel} = {st, pa, fl, tm};
        {echo_en, verbose_en, debug_en, delay_sec} = {ec, vb, db, dl};
        baud_sel = 4'h8 + 4'($urandom_range(0, 7));
        u_host.par = pa;
        cfg_write = 1'b1;
        @(negedge clk);
        cfg_write = 1'b0;
    endtask : cfg
    task automatic pulse(ref logic s);
        @(negedge clk);
        s = 1'b1;
        @(negedge clk);
        s = 1'b0;
    endtask : pulse
    // queues a byte and the terminator chosen for replies
    task automatic expect_line(input logic [7:0] d, input logic [1:0] tm);
        exp_q.push_back(d);
        exp_q.push_back((tm == TERM_LF || tm == TERM_LFCR) ? `CHAR_LF : `CHAR_CR);
        if (tm == TERM_CRLF || tm == TERM_LFCR)
            exp_q.push_back((tm == TERM_CRLF) ? `CHAR_LF : `CHAR_CR);
    endtask : expect_line
    // every expected byte against what the host decoded, in order
    task automatic drain(input string name);
        int k;
        logic [8:0] g;
        while (exp_q.size() > 0) begin
            for (k = 0; k < 20000 && u_host.q.size() == 0; k++) @(negedge clk);
            g = (u_host.q.size() > 0) ? {1'b0, u_host.q.pop_front()} : 9'h100;
            check(name, g, {1'b0, exp_q.pop_front()});
        end
    endtask : drain
    task automatic wait_rx(input logic [7:0] d, input logic perr);
        int k;
        for (k = 0; k < 8000 && rx_valid !== 1'b1; k++) @(negedge clk);
        check("rx_data", {1'b0, rx_data}, {1'b0, d});
        check("rx_parity_err", {8'h00, rx_parity_err}, {8'h00, perr});
        check("rx_frame_err", {8'h00, rx_frame_err}, 9'h0);
    endtask : wait_rx
    // hands one reply byte over; ready is looked at mid-cycle, taken on the next edge
    task automatic reply(input logic [7:0] d, output int waited);
        @(negedge clk);
        {reply_data, reply_valid, reply_last} = {d, 2'b11};
        waited = 0;
        while (reply_ready !== 1'b1 && waited < 30000) begin
            @(negedge clk);
            waited++;
        end
        @(negedge clk);
        reply_valid = 1'b0;
    endtask : reply
    initial begin : main
        logic [7:0] d;
        int w, v;
        void'($urandom(32'h46069201));
        u_host.bit_cyc = 16 * `DIV_19200;
        repeat (4) @(negedge clk);
        nrst = 1'b1;
        repeat (2) @(negedge clk);
        check("txd_idle", {8'h00, txd}, 9'h1);
        check("dsr_idle", {8'h00, dsr}, 9'h1);
        check("ready_idle", {8'h00, reply_ready}, 9'h1);
        rx_space = 8'($urandom_range(8, 255));
        // echo and trace, even parity, two stop bits, kept over settings init
        cfg(STOP_2, PAR_EVEN, FLOW_NONE, TERM_LF, 1'b1, 1'b0, 1'b1, 6'h00);
        pulse(settings_init);
        d = 8'($urandom());
        exp_q.push_back(d);
        fork
            u_host.send(d, 1'b0, 32);
            begin
                wait_rx(d, 1'b0);
                @(negedge clk);
                check("trace", {trace_valid, trace_data}, {1'b1, d});
            end
        join
        drain("echo");
        $display("test echo done");
        // echo off, odd parity broken on purpose, stop of one and a half
        cfg(STOP_15, PAR_ODD, FLOW_NONE, TERM_LF, 1'b0, 1'b0, 1'b0, 6'h00);
        d = 8'($urandom());
        fork
            u_host.send(d, 1'b1, 24);
            begin
                wait_rx(d, 1'b1);
                @(negedge clk);
                check("no_trace", {8'h00, trace_valid}, 9'h0);
            end
        join
        repeat (600) @(negedge clk);
        check("no_echo", {txd, 8'(u_host.q.size())}, 9'h100);
        $display("test parity done");
        // every terminator, each reply behind a three second delay
        for (int t = 0; t < 4; t++) begin
            cfg(STOP_1, PAR_NONE, FLOW_NONE, 2'(t), 1'b0, 1'b0, 1'b0, 6'h03);
            pulse(cmd_received);
            d = 8'($urandom());
            expect_line(d, 2'(t));
            // the slot takes the byte at once; the delay shows as a late start bit
            fork
                reply(d, v);
                for (w = 0; w < 30000 && txd !== 1'b0; w++) @(negedge clk);
            join
            check("delay", 9'(w >= 300), 9'h1);
            drain("reply");
        end
        $display("test terminators done");
        cfg(STOP_1, PAR_NONE, FLOW_NONE, TERM_CR, 1'b0, 1'b1, 1'b0, 6'h00);
        cmd_ok = 1'($urandom());
        expect_line(cmd_ok ? `CHAR_CMD_OK : `CHAR_CMD_FAIL, TERM_CR);
        pulse(cmd_done);
        drain("status");
        $display("test status done");
        // in-band stop while two entries remain, resume at eight
        cfg(STOP_1, PAR_NONE, FLOW_SOFT, TERM_LF, 1'b0, 1'b0, 1'b0, 6'h00);
        rx_space = 8'h02;
        exp_q.push_back(`CHAR_XOFF);
        drain("halt");
        rx_space = 8'h08;
        exp_q.push_back(`CHAR_XON);
        drain("resume");
        $display("test soft flow done");
        // hardware lines: our ready drops, the host's hold stalls a reply
        cfg(STOP_1, PAR_NONE, FLOW_HARD, TERM_LF, 1'b0, 1'b0, 1'b0, 6'h00);
        rx_space = 8'h01;
        repeat (10) @(negedge clk);
        check("dsr_stop", {8'h00, dsr}, 9'h0);
        rx_space = 8'($urandom_range(8, 255));
        u_host.dtr = 1'b0;
        d = 8'($urandom());
        expect_line(d, TERM_LF);
        fork
            reply(d, w);
            begin
                repeat (2000) @(negedge clk);
                check("dtr_hold", {txd, 8'(u_host.q.size())}, 9'h100);
                u_host.dtr = 1'b1;
            end
        join
        drain("hard");
        check("dsr_go", {8'h00, dsr}, 9'h1);
        check("host_frames", 9'(u_host.bad), 9'h0);
        $display("test hard flow done");
        complete_run();
    end
    // cuts a hang short about a tenth past the expected length of the run
    initial begin : watchdog
        repeat (112000) @(posedge clk);
        n_fail++;
        $display("[ERR] watchdog expected finish seen hang");
        complete_run();
    end
endmodule : tb_top
`default_nettype wire
